// File: common/ccu_defs.vh
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH

// Register offsets on the register port
`define CCU_ADDR_PERIPHERAL_FLAGS   8'h0c
`define CCU_ADDR_CAPTURE_CMP_LOW    8'h15
`define CCU_ADDR_CAPTURE_CMP_HIGH   8'h16
`define CCU_ADDR_UNIT_CONTROL       8'h17
`define CCU_ADDR_PERIPHERAL_ENABLES 8'h8c

// Reset values
`define CCU_RST_PERIPHERAL_FLAGS    8'h00
`define CCU_RST_PERIPHERAL_ENABLES  8'h00
`define CCU_RST_UNIT_CONTROL        6'h00
`define CCU_RST_CAPTURE_CMP         16'h0000

// Field positions
`define CCU_BIT_UNIT_EVENT_FLAG     2
`define CCU_BIT_UNIT_EVENT_IRQ_EN   2
`define CCU_BIT_DUTY_LOW_BIT1       5
`define CCU_BIT_DUTY_LOW_BIT0       4
`define CCU_CTRL_MODE_HI            3
`define CCU_CTRL_MODE_LO            0

// Mode codes
`define CCU_MODE_DISABLED           4'h0
`define CCU_MODE_CAP_FALL           4'h4
`define CCU_MODE_CAP_RISE           4'h5
`define CCU_MODE_CAP_RISE4          4'h6
`define CCU_MODE_CAP_RISE16         4'h7
`define CCU_MODE_CMP_SET            4'h8
`define CCU_MODE_CMP_CLEAR          4'h9
`define CCU_MODE_CMP_FLAG           4'ha
`define CCU_MODE_CMP_SPECIAL        4'hb

// Mode groups in the upper two mode bits
`define CCU_GROUP_CAPTURE           2'h1
`define CCU_GROUP_COMPARE           2'h2
`define CCU_GROUP_PWM               2'h3

// Prescaler edge counts
`define CCU_PRESCALE_4_LAST         4'h3
`define CCU_PRESCALE_16_LAST        4'hf

`endif

// File: logic/ccu_edge_prescaler.v
`include "ccu_defs.vh"

// Turns pin edges into capture events for the selected capture mode
module ccu_edge_prescaler (
  input  wire       clk,          // Core clock
  input  wire       rstn,         // Asynchronous reset, active low
  input  wire       clear,        // Holds the edge counter at zero
  input  wire [1:0] sel,          // Low two mode bits of a capture mode
  input  wire       rise,         // One-cycle rising edge seen on the pin
  input  wire       fall,         // One-cycle falling edge seen on the pin
  output wire       capture_event // One-cycle qualified capture
);

  reg  [3:0] edge_count;          // Rising edges seen since last capture
  reg  [3:0] next_edge_count;     // Next value of the counter
  wire [3:0] last_count;          // Count at which a capture fires
  wire       counted_mode;        // Four- or sixteen-edge setting

  // Selects the terminal count of the chosen setting
  assign counted_mode = sel[1];
  assign last_count   = sel[0] ? `CCU_PRESCALE_16_LAST : `CCU_PRESCALE_4_LAST;

  // Single-edge settings fire at once, counted ones at the terminal count
  assign capture_event = counted_mode ? (rise && (edge_count >= last_count)) // R3 R22
                                      : (sel[0] ? rise : fall);               // R2

  // Counts qualifying rising edges and restarts after each counted capture
  always @* begin
    next_edge_count = edge_count;
    if (clear) begin
      next_edge_count = 4'h0;                          // R17
    end else if (counted_mode && rise) begin
      if (edge_count >= last_count) begin
        next_edge_count = 4'h0;                        // R22
      end else begin
        next_edge_count = edge_count + 4'h1;           // R3
      end
    end
  end

  // Counter register; a switch between settings keeps the count
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_count <= 4'h0;                              // R17
    end else begin
      edge_count <= next_edge_count;                   // R18
    end
  end

endmodule

// File: logic/ccu_top.v
`include "ccu_defs.vh"

// Overview of operation
// R1: Mode 0000 holds unit in reset
// R2: Capture each falling or rising pin edge
// R3: Capture every fourth or sixteenth rising edge
// R4: Compare match drives pin high, sets flag
// R5: Compare match drives pin low, sets flag
// R6: Compare match only sets the flag
// R7: Special event: flag, clear timebase, start conversion
// R8: PWM mode; duty low bits from control
// R9: Control bits 7 and 6 read zero
// R10: Capture copies full timebase into value
// R11: Capture sets flag; only software clears
// R12: New capture overwrites unread old value
// R13: Software makes pin input for capture
// R14: Edge detection watches pin even when driven
// R15: Timebase must run synchronously for capture
// R16: Mode change may raise spurious flag
// R17: Prescaler cleared when off or not capturing
// R18: Switching prescaler settings keeps its count
// R19: Software writes zero before new prescaler
// R20: Software prepares PWM before selecting it
// R21: Compare match on equality, once per match
// R22: Counted edges capture then restart from zero
module ccu_top (
  input  wire        clk,                   // Core clock, 40 MHz
  input  wire        rstn,                  // Asynchronous reset, active low
  input  wire [7:0]  reg_addr,              // Register address
  input  wire [7:0]  reg_wdata,             // Register write data
  input  wire        reg_wr,                // Write strobe, one cycle
  input  wire        reg_rd,                // Read strobe, one cycle
  output reg  [7:0]  reg_rdata,             // Read data, cycle after the strobe
  input  wire [15:0] timebase16,            // Running sixteen-bit timebase count
  input  wire        adc_enabled,           // Converter is switched on
  input  wire        unit_pin_in,           // Level seen on the unit pin
  output reg         unit_pin_out,          // Compare output latch
  output wire        unit_pin_oe,           // High while the unit drives the pin
  output reg         timebase_clear,        // One-cycle pulse clearing the timebase
  output reg         adc_start,             // One-cycle pulse starting a conversion
  output reg         pwm_active,            // Unit is in PWM mode
  output reg  [9:0]  pwm_duty,              // Ten-bit duty value for the PWM stage
  output wire        unit_event_flag,       // Sticky event flag
  output wire        unit_event_irq_enable  // Event enable bit from software
);

  // Software visible state
  reg  [5:0]  unit_control;        // Duty low bits and mode select
  reg  [15:0] capture_compare_value; // High and low value bytes
  reg         event_flag;          // Sticky event flag bit
  reg         irq_enable;          // Event enable bit

  // Internal state
  reg         pin_prev;            // Pin level one cycle ago
  reg         match_prev;          // Equality seen one cycle ago

  // Decoded mode and bus terms
  wire [3:0]  mode_select;         // Four mode bits
  wire [1:0]  mode_group;          // Upper two mode bits
  wire        mode_off;            // Unit disabled or on a spare code
  wire        mode_capture;        // One of the four capture modes
  wire        mode_compare;        // One of the four compare modes
  wire        mode_pwm;            // PWM mode
  wire        wr_flags;            // Write to the flag register
  wire        wr_enables;          // Write to the enable register
  wire        wr_low;              // Write to the low value byte
  wire        wr_high;             // Write to the high value byte
  wire        wr_control;          // Write to the control register

  // Event terms
  wire        pin_rise;            // Rising edge on the pin
  wire        pin_fall;            // Falling edge on the pin
  wire        capture_event;       // Qualified capture
  wire        match_now;           // Timebase equals the stored value
  wire        match_event;         // First cycle of a match
  wire        compare_event;       // Match acted on in a compare mode

  // Next values
  reg  [15:0] next_capture_compare_value; // Value after this cycle
  reg         next_event_flag;     // Flag after this cycle
  reg         next_unit_pin_out;   // Output latch after this cycle
  reg  [7:0]  next_reg_rdata;      // Read data for the next cycle

  // Mode decode from the control register
  assign mode_select  = unit_control[`CCU_CTRL_MODE_HI:`CCU_CTRL_MODE_LO];
  assign mode_group   = mode_select[3:2];
  assign mode_capture = (mode_group == `CCU_GROUP_CAPTURE);
  assign mode_compare = (mode_group == `CCU_GROUP_COMPARE);
  assign mode_pwm     = (mode_group == `CCU_GROUP_PWM);          // R8
  assign mode_off     = !(mode_capture || mode_compare || mode_pwm); // R1

  // Address decode of the write strobe
  assign wr_flags   = reg_wr && (reg_addr == `CCU_ADDR_PERIPHERAL_FLAGS);
  assign wr_enables = reg_wr && (reg_addr == `CCU_ADDR_PERIPHERAL_ENABLES);
  assign wr_low     = reg_wr && (reg_addr == `CCU_ADDR_CAPTURE_CMP_LOW);
  assign wr_high    = reg_wr && (reg_addr == `CCU_ADDR_CAPTURE_CMP_HIGH);
  assign wr_control = reg_wr && (reg_addr == `CCU_ADDR_UNIT_CONTROL);

  // Edge detection looks at the pin level whoever drives it
  assign pin_rise = unit_pin_in && !pin_prev;   // R14
  assign pin_fall = !unit_pin_in && pin_prev;   // R14

  // Edge prescaler, held clear outside capture modes
  ccu_edge_prescaler u_prescaler (
    .clk           (clk),
    .rstn          (rstn),
    .clear         (!mode_capture),              // R17
    .sel           (mode_select[1:0]),
    .rise          (pin_rise && mode_capture),
    .fall          (pin_fall && mode_capture),
    .capture_event (capture_event)
  );

  // Equality match, acted on only in its first cycle
  assign match_now     = (timebase16 == capture_compare_value); // R21
  assign match_event   = match_now && !match_prev;              // R21
  assign compare_event = mode_compare && match_event;

  // Pin is driven in compare and PWM modes
  assign unit_pin_oe = mode_compare || mode_pwm;

  // Register outputs seen by the rest of the chip
  assign unit_event_flag       = event_flag;
  assign unit_event_irq_enable = irq_enable;

  // Pin history for edge detection
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= unit_pin_in;                  // R14
    end
  end

  // Match history; cleared while not comparing so a standing match acts on entry
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_prev <= 1'b0;
    end else if (!mode_compare) begin
      match_prev <= 1'b0;                       // R1
    end else begin
      match_prev <= match_now;                  // R21
    end
  end

  // Control register; bits 7 and 6 are not stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_control <= `CCU_RST_UNIT_CONTROL;
    end else if (wr_control) begin
      unit_control <= reg_wdata[5:0];           // R9
    end
  end

  // Enable register; only the event enable bit exists here
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable <= 1'b0;                       // Enable bit resets clear
    end else if (wr_enables) begin
      irq_enable <= reg_wdata[`CCU_BIT_UNIT_EVENT_IRQ_EN];
    end
  end

  // Value register: software bytes, overwritten by a capture
  always @* begin
    next_capture_compare_value = capture_compare_value;
    if (wr_low) begin
      next_capture_compare_value[7:0] = reg_wdata;
    end
    if (wr_high) begin
      next_capture_compare_value[15:8] = reg_wdata;
    end
    // Capture wins over a software write in the same cycle
    if (capture_event) begin
      next_capture_compare_value = timebase16;  // R10 R12
    end
  end

  // Value register storage
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_compare_value <= `CCU_RST_CAPTURE_CMP;
    end else begin
      capture_compare_value <= next_capture_compare_value;
    end
  end

  // Event flag: software write first, hardware set wins over a clear
  always @* begin
    next_event_flag = event_flag;
    if (wr_flags) begin
      next_event_flag = reg_wdata[`CCU_BIT_UNIT_EVENT_FLAG]; // R11
    end
    // A mode change does not mask an edge already in flight
    if (capture_event) begin
      next_event_flag = 1'b1;                   // R11 R16
    end
    // Every compare mode raises the flag on a match
    if (compare_event) begin
      next_event_flag = 1'b1;                   // R4 R5 R6 R7
    end
  end

  // Event flag storage; the unit never clears it by itself
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_flag <= 1'b0;
    end else begin
      event_flag <= next_event_flag;            // R11
    end
  end

  // Compare output latch
  always @* begin
    next_unit_pin_out = unit_pin_out;
    if (mode_off || mode_capture) begin
      next_unit_pin_out = 1'b0;                 // R1
    end else if (compare_event) begin
      case (mode_select)
        // Drive high on match
        `CCU_MODE_CMP_SET: begin
          next_unit_pin_out = 1'b1;             // R4
        end
        // Drive low on match
        `CCU_MODE_CMP_CLEAR: begin
          next_unit_pin_out = 1'b0;             // R5
        end
        // Flag-only and special event modes leave the pin alone
        `CCU_MODE_CMP_FLAG: begin
          next_unit_pin_out = unit_pin_out;     // R6
        end
        `CCU_MODE_CMP_SPECIAL: begin
          next_unit_pin_out = unit_pin_out;     // R7
        end
        default: begin
          next_unit_pin_out = unit_pin_out;
        end
      endcase
    end
  end

  // Output latch storage
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_pin_out <= 1'b0;
    end else begin
      unit_pin_out <= next_unit_pin_out;
    end
  end

  // Special event pulses; timebase clears even with the converter off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timebase_clear <= 1'b0;
      adc_start      <= 1'b0;
    end else begin
      timebase_clear <= compare_event && (mode_select == `CCU_MODE_CMP_SPECIAL); // R7
      adc_start      <= compare_event && (mode_select == `CCU_MODE_CMP_SPECIAL)
                        && adc_enabled;                                           // R7
    end
  end

  // PWM duty: upper byte from the low value byte, low bits from control
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_active <= 1'b0;
      pwm_duty   <= 10'h000;
    end else begin
      pwm_active <= mode_pwm;                   // R8
      pwm_duty   <= {capture_compare_value[7:0],
                     unit_control[`CCU_BIT_DUTY_LOW_BIT1],
                     unit_control[`CCU_BIT_DUTY_LOW_BIT0]}; // R8
    end
  end

  // Read multiplexer; unmapped addresses and idle cycles give zero
  always @* begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        // Only the event flag bit is held here
        `CCU_ADDR_PERIPHERAL_FLAGS: begin
          next_reg_rdata[`CCU_BIT_UNIT_EVENT_FLAG] = event_flag;
        end
        // Only the event enable bit is held here
        `CCU_ADDR_PERIPHERAL_ENABLES: begin
          next_reg_rdata[`CCU_BIT_UNIT_EVENT_IRQ_EN] = irq_enable;
        end
        // Low value byte
        `CCU_ADDR_CAPTURE_CMP_LOW: begin
          next_reg_rdata = capture_compare_value[7:0];
        end
        // High value byte
        `CCU_ADDR_CAPTURE_CMP_HIGH: begin
          next_reg_rdata = capture_compare_value[15:8];
        end
        // Control with the two top bits reading zero
        `CCU_ADDR_UNIT_CONTROL: begin
          next_reg_rdata = {2'b00, unit_control}; // R9
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data register, valid only in the cycle after the strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// File: verif/ccu_chk.sv
`include "ccu_defs.vh"

// Watches register reads, compare pulses, flag and duty outputs
module ccu_chk (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       adc_enabled,
  input wire       unit_pin_out,
  input wire       unit_pin_oe,
  input wire       timebase_clear,
  input wire       adc_start,
  input wire       pwm_active,
  input wire [9:0] pwm_duty,
  input wire       unit_event_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Decoded software writes
  wire wr_ctl = reg_wr && reg_addr == `CCU_ADDR_UNIT_CONTROL;
  wire wr_low = reg_wr && reg_addr == `CCU_ADDR_CAPTURE_CMP_LOW;
  wire clr_flg = reg_wr && reg_addr == `CCU_ADDR_PERIPHERAL_FLAGS && !reg_wdata[2];

  chk_ctl_top_zero: assert property (reg_rd && reg_addr == `CCU_ADDR_UNIT_CONTROL |=> reg_rdata[7:6] == 2'h0)
    else $error("control upper bits not zero");
  chk_adc_gate: assert property ((timebase_clear || adc_start) |-> timebase_clear && adc_start == $past(adc_enabled))
    else $error("conversion start not gated by converter enable");
  chk_clear_once: assert property (timebase_clear |=> !timebase_clear)
    else $error("timebase clear longer than one cycle");
  chk_clear_flag: assert property (timebase_clear |-> unit_event_flag)
    else $error("special event without flag");
  chk_flag_sticky: assert property ($fell(unit_event_flag) |-> $past(clr_flg))
    else $error("flag cleared without software");
  chk_duty_bits: assert property (wr_ctl ##1 !wr_ctl |=> pwm_duty[1:0] == $past(reg_wdata[5:4], 2))
    else $error("duty low bits wrong");
  chk_duty_byte: assert property (wr_low && unit_pin_oe ##1 !wr_low && unit_pin_oe |=> pwm_duty[9:2] == $past(reg_wdata, 2))
    else $error("duty upper byte wrong");
  chk_off_pin_low: assert property (!unit_pin_oe ##1 !unit_pin_oe |-> !unit_pin_out)
    else $error("output latch set while not driving");
  chk_pin_on_match: assert property (unit_pin_oe && $changed(unit_pin_out) |-> unit_event_flag)
    else $error("output moved without a match");
  chk_pwm_drives: assert property ($rose(pwm_active) |-> $past(unit_pin_oe))
    else $error("pwm without pin drive");

  // Main scenarios reached
  cov_special: cover property (timebase_clear && adc_start);
  cov_flag_clear: cover property ($fell(unit_event_flag));
  cov_pwm: cover property ($rose(pwm_active));
endmodule

bind ccu_top ccu_chk u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_enabled(adc_enabled), .unit_pin_out(unit_pin_out),
  .unit_pin_oe(unit_pin_oe), .timebase_clear(timebase_clear), .adc_start(adc_start), .pwm_active(pwm_active),
  .pwm_duty(pwm_duty), .unit_event_flag(unit_event_flag));

// File: verif/ccu_pin_model.sv
// Outside world at the unit pin: a source that the bench steers
module ccu_pin_model (
  input  wire unit_pin_out,
  input  wire unit_pin_oe,
  input  wire ext_level,
  output wire pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unit drive wins; edge logic still sees the wire level
  assign pin = unit_pin_oe ? unit_pin_out : ext_level;
endmodule

// File: verif/tb_ccu_top.sv
`include "ccu_defs.vh"

// Register-level bench for the capture/compare unit
module tb_ccu_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [15:0] timebase16 = 16'h0000;
  reg         adc_enabled = 1'b0;
  reg         ext_level = 1'b0;
  reg  [15:0] val;
  reg  [3:0]  mode;
  wire        pin;
  wire [7:0]  reg_rdata;
  wire [9:0]  pwm_duty;
  wire        unit_pin_out, unit_pin_oe, timebase_clear, adc_start, pwm_active, unit_event_flag, irq_en;
  integer     num_errors = 0, comparisons = 0, i, m, n, ncl, nad;

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  ccu_top uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timebase16(timebase16), .adc_enabled(adc_enabled),
    .unit_pin_in(pin), .unit_pin_out(unit_pin_out), .unit_pin_oe(unit_pin_oe), .timebase_clear(timebase_clear),
    .adc_start(adc_start), .pwm_active(pwm_active), .pwm_duty(pwm_duty), .unit_event_flag(unit_event_flag),
    .unit_event_irq_enable(irq_en));
  ccu_pin_model u_pin (.unit_pin_out(unit_pin_out), .unit_pin_oe(unit_pin_oe), .ext_level(ext_level), .pin(pin));

  // Compare and count
  task check(input [8*9:1] name, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // One-cycle register write
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  // One-cycle read, data checked in the following cycle
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    end
  endtask

  // Full pulses on the pin, three cycles high, then four low (three after the last)
  task pulses(input integer k);
    begin
      repeat (k) begin
        @(posedge clk);
        ext_level <= 1'b1;
        repeat (3) @(posedge clk);
        ext_level <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end
  endtask

  // Holds a match with 0x4000 for four cycles, counting pulses
  task match;
    begin
      ncl = 0;
      nad = 0;
      @(posedge clk);
      timebase16 <= 16'h4000;
      repeat (4) begin
        @(posedge clk);
        #1;
        ncl = ncl + timebase_clear;
        nad = nad + adc_start;
      end
      timebase16 <= 16'h0000;
    end
  endtask

  // Verdict and end of run
  task test_done;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, unmapped place, enable bit
    rd(8'h0c, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h17, 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(8'h8c, 8'hff);
    rd(8'h8c, 8'h04);
    check("irq_en", 16'h0001, {15'h0, irq_en});
    // PWM duty from low byte and control bits
    wr(8'h15, 8'ha5);
    wr(8'h17, 8'hfc);
    rd(8'h17, 8'h3c);
    check("pwm_duty", 16'h0297, {6'h0, pwm_duty});
    check("pwm_act", 16'h0001, {15'h0, pwm_active});
    // Low value byte written while in PWM reaches the duty one cycle later
    wr(8'h15, 8'h5a);
    rd(8'h15, 8'h5a);
    check("pwm_duty", 16'h016b, {6'h0, pwm_duty});
    // Capture on one, one, four and sixteen edges
    for (m = 0; m < 4; m = m + 1) begin
      n = (m < 2) ? 1 : (m == 2) ? 4 : 16;
      val = 16'h1357 + m[15:0];
      wr(8'h17, 8'h00);
      wr(8'h17, {4'h0, 4'h4 + m[3:0]});
      wr(8'h0c, 8'h00);
      pulses(n - 1);
      rd(8'h0c, 8'h00);
      timebase16 <= val;
      pulses(1);
      rd(8'h0c, 8'h04);
      timebase16 <= ~val;
      wr(8'h0c, 8'h00);
      pulses(n - 1);
      rd(8'h0c, 8'h00);
      pulses(1);
      rd(8'h16, ~val[15:8]);
      rd(8'h15, ~val[7:0]);
    end
    // Turning the unit off restarts the edge count
    wr(8'h17, 8'h06);
    pulses(3);
    wr(8'h17, 8'h00);
    wr(8'h17, 8'h06);
    wr(8'h0c, 8'h00);
    pulses(3);
    rd(8'h0c, 8'h00);
    pulses(1);
    rd(8'h0c, 8'h04);
    // Direct switch of edge count keeps the count
    pulses(3);
    wr(8'h17, 8'h07);
    wr(8'h0c, 8'h00);
    pulses(12);
    rd(8'h0c, 8'h00);
    pulses(1);
    rd(8'h0c, 8'h04);
    // Compare modes against value 0x4000
    wr(8'h17, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h40);
    for (i = 0; i < 6; i = i + 1) begin
      mode = (i == 0 || i == 2) ? 4'h8 : (i == 1) ? 4'h9 : (i == 3) ? 4'ha : 4'hb;
      adc_enabled <= (i == 5);
      wr(8'h17, {4'h0, mode});
      wr(8'h0c, 8'h00);
      match;
      rd(8'h0c, 8'h04);
      check("pin_out", {15'h0, i != 1}, {15'h0, unit_pin_out});
      check("clear", {15'h0, i > 3}, ncl[15:0]);
      check("adc", {15'h0, i == 5}, nad[15:0]);
    end
    check("oe", 16'h0001, {15'h0, unit_pin_oe});
    // Disabled mode clears the unit, value bytes kept
    wr(8'h17, 8'h00);
    rd(8'h16, 8'h40);
    check("pin_out", 16'h0000, {15'h0, unit_pin_out});
    check("oe", 16'h0000, {15'h0, unit_pin_oe});
    check("pwm_act", 16'h0000, {15'h0, pwm_active});
    test_done;
  end
endmodule
